// file: rtl/pcbl_loader.sv
// Control block loader: fetches the block and segment selector,
// caches fields, resolves interrupt and fault table addresses.
// Assumes a word-read memory port answering with a one-cycle valid.
`timescale 1ns/100ps
`include "pcbl_map.svh"
module pcbl_loader (
  // Clock and reset
  input  wire logic              i_core_clk,
  input  wire logic              i_sys_rst,
  // Start and messages
  input  wire logic              i_init,
  input  wire logic [31:0]       i_block_ptr,
  input  wire logic [31:0]       i_segtab_ptr,
  input  wire pcbl_pkg::pcbl_msg_t i_msg_cmd,
  input  wire logic [31:0]       i_msg_data,
  // Memory read port
  output logic                   o_mem_req,
  output logic [31:0]            o_mem_addr,
  input  wire logic              i_mem_valid,
  input  wire logic [31:0]       i_mem_data,
  // Events
  input  wire logic              i_int_req,
  input  wire logic [7:0]        i_int_vector,
  input  wire logic [4:0]        i_int_prio,
  input  wire logic [4:0]        i_cur_prio,
  input  wire logic              i_fault,
  input  wire logic [7:0]        i_fault_vector,
  // Results
  output logic                   o_busy,
  output pcbl_pkg::pcbl_run_t    o_run_state,
  output logic                   o_virtual_mode,
  output logic                   o_mp_preempt,
  output logic [31:0]            o_segtab_sel,
  output logic [31:0]            o_dispatch_sel,
  output logic [31:0]            o_int_stack,
  output logic [31:0]            o_region3_sel,
  output logic [31:0]            o_sysproc_sel,
  output logic [63:0]            o_idle_time,
  output logic                   o_int_take,
  output logic                   o_int_defer,
  output logic                   o_fault_take,
  output logic [31:0]            o_entry_addr
);
  import pcbl_pkg::*;

  typedef enum logic [1:0] {
    PCBL_FS_IDLE, PCBL_FS_SEG, PCBL_FS_BLOCK
  } pcbl_fsm_t;

  localparam int NW = 10;
  localparam logic [5:0] OFS [NW] = '{`PCBL_OFS_CTRL, `PCBL_OFS_DISPATCH,
    `PCBL_OFS_INT_TABLE, `PCBL_OFS_INT_STACK, `PCBL_OFS_REGION3,
    `PCBL_OFS_SYSPROC, `PCBL_OFS_FAULT_TABLE, `PCBL_OFS_IDLE_LO,
    `PCBL_OFS_IDLE_HI, 6'd0};
  localparam logic [5:0] LAST = 6'(`PCBL_BLOCK_WORDS - 1);

  pcbl_fsm_t   fs_reg, fs_next;
  logic [5:0]  idx_reg, idx_next;
  logic        pend_reg, pend_next;
  logic [31:0] base_reg, base_next;
  logic        req_reg, req_next;
  logic [31:0] addr_reg, addr_next;
  logic        itake_reg, itake_next, idef_reg, idef_next;
  logic        ftake_reg, ftake_next;
  logic [31:0] entry_reg, entry_next;
  logic [NW-1:0] ld;
  logic [31:0] wdata [NW];
  logic [31:0] q [NW];
  logic        modify;

  // Cached words; slot 9 is the segment selector
  genvar g;
  generate
    for (g = 0; g < NW; g++) begin : gen_w
      pcbl_word_reg #(.W(32)) u_w (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .i_load     (ld[g]),
        .i_data     (wdata[g]),
        .o_q        (q[g])
      );
    end
  endgenerate

  // Interagent message updates only touch cached copies
  assign modify = (i_msg_cmd == PCBL_MSG_MODIFY_CTRL) &&
                  (fs_reg == PCBL_FS_IDLE);

  // Word load strobes
  always_comb begin
    for (int k = 0; k < NW; k++) begin
      ld[k] = 1'b0;
      wdata[k] = i_mem_data;
      if (fs_reg == PCBL_FS_BLOCK && i_mem_valid && k < 9 &&
          idx_reg == OFS[k]) begin
        ld[k] = 1'b1;
      end
    end
    if (fs_reg == PCBL_FS_SEG && i_mem_valid) begin
      ld[9] = 1'b1;
    end
    // State field keeps its old value; takes effect only on restart
    if (modify) begin
      ld[0] = 1'b1;
      wdata[0] = {i_msg_data[31:4], q[0][3:2], i_msg_data[1:0]};
    end
  end

  // Fetch sequencer: selector first, then the whole block
  always_comb begin
    fs_next = fs_reg;
    idx_next = idx_reg;
    pend_next = pend_reg;
    base_next = base_reg;
    req_next = 1'b0;
    addr_next = addr_reg;
    case (fs_reg)
      PCBL_FS_IDLE: begin
        // Memory is never revisited except on init or restart
        if (i_init || i_msg_cmd == PCBL_MSG_RESTART) begin
          base_next = i_block_ptr;
          fs_next = PCBL_FS_SEG;
          req_next = 1'b1;
          addr_next = i_segtab_ptr;
          pend_next = 1'b1;
        end
      end
      PCBL_FS_SEG: begin
        if (i_mem_valid) begin
          fs_next = PCBL_FS_BLOCK;
          idx_next = 6'd0;
          req_next = 1'b1;
          addr_next = base_reg;
        end
      end
      PCBL_FS_BLOCK: begin
        if (i_mem_valid) begin
          if (idx_reg == LAST) begin
            fs_next = PCBL_FS_IDLE;
            pend_next = 1'b0;
          end else begin
            idx_next = 6'(idx_reg + 6'd1);
            req_next = 1'b1;
            addr_next = base_reg + {24'h0, idx_next, 2'b00};
          end
        end
      end
      default: fs_next = PCBL_FS_IDLE;
    endcase
  end

  // Events: fault wins over interrupt; both are ignored while a block load is pending
  always_comb begin
    itake_next = 1'b0;
    idef_next = 1'b0;
    ftake_next = 1'b0;
    entry_next = entry_reg;
    if (!pend_reg && i_fault) begin
      ftake_next = 1'b1;
      entry_next = q[6] + {22'h0, i_fault_vector, 2'b00};
    end else if (!pend_reg && i_int_req) begin
      if (i_int_prio > i_cur_prio) begin
        itake_next = 1'b1;
        entry_next = q[2] + {22'h0, i_int_vector, 2'b00};
      end else begin
        idef_next = 1'b1;
      end
    end
  end

  // State registers
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      fs_reg <= PCBL_FS_IDLE;
      idx_reg <= 6'd0;
      pend_reg <= 1'b0;
      base_reg <= `PCBL_RST_WORD;
      req_reg <= 1'b0;
      addr_reg <= `PCBL_RST_WORD;
      itake_reg <= 1'b0;
      idef_reg <= 1'b0;
      ftake_reg <= 1'b0;
      entry_reg <= `PCBL_RST_WORD;
    end else begin
      fs_reg <= fs_next;
      idx_reg <= idx_next;
      pend_reg <= pend_next;
      base_reg <= base_next;
      req_reg <= req_next;
      addr_reg <= addr_next;
      itake_reg <= itake_next;
      idef_reg <= idef_next;
      ftake_reg <= ftake_next;
      entry_reg <= entry_next;
    end
  end

  // Outputs from flip-flops
  assign o_busy = pend_reg;
  assign o_mem_req = req_reg;
  assign o_mem_addr = addr_reg;
  assign o_run_state = pcbl_run_t'(q[0][`PCBL_BIT_STATE_LO +: 2]);
  assign o_virtual_mode = q[0][`PCBL_BIT_ADDR_MODE];
  assign o_mp_preempt = q[0][`PCBL_BIT_MP_PREEMPT];
  assign o_segtab_sel = q[9];
  assign o_dispatch_sel = q[1];
  assign o_int_stack = q[3];
  assign o_region3_sel = q[4];
  assign o_sysproc_sel = q[5];
  assign o_idle_time = {q[8], q[7]};
  assign o_int_take = itake_reg;
  assign o_int_defer = idef_reg;
  assign o_fault_take = ftake_reg;
  assign o_entry_addr = entry_reg;

  // Checks
  sequence s_seg_fetch;
    (fs_reg == PCBL_FS_SEG) && i_mem_valid;
  endsequence
  a_seg_sel_load: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst) s_seg_fetch |=> o_segtab_sel == $past(i_mem_data))
    else $error("selector not captured");
  a_no_fetch_idle: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst) (fs_reg == PCBL_FS_IDLE) && !i_init &&
    i_msg_cmd != PCBL_MSG_RESTART |=> !o_mem_req)
    else $error("unprompted memory read");
  a_first_fetch: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst) (fs_reg == PCBL_FS_IDLE) && i_init |=>
    o_mem_req && o_mem_addr == $past(i_segtab_ptr))
    else $error("segment pointer not used physically");
  a_block_start: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst) s_seg_fetch |=> o_mem_addr == base_reg)
    else $error("block fetch not at block start");
  a_block_end: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst) (fs_reg == PCBL_FS_BLOCK) && i_mem_valid &&
    idx_reg == 6'd43 |=> !o_busy)
    else $error("block length wrong");
  a_fault_take: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst) !o_busy && i_fault |=> o_fault_take &&
    o_entry_addr == $past(q[6]) + {22'h0, $past(i_fault_vector), 2'b00})
    else $error("fault entry wrong");
  a_fault_first: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst) !o_busy && i_fault && i_int_req |=>
    o_fault_take && !o_int_take && !o_int_defer)
    else $error("fault not given priority");
  a_int_prio: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst) !o_busy && !i_fault && i_int_req &&
    i_int_prio <= i_cur_prio |=> o_int_defer && !o_int_take)
    else $error("low priority interrupt taken");
  a_int_entry: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst) !o_busy && !i_fault && i_int_req &&
    i_int_prio > i_cur_prio |=> o_int_take &&
    o_entry_addr == $past(q[2]) + {22'h0, $past(i_int_vector), 2'b00})
    else $error("interrupt entry wrong");
  a_state_hold: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst) modify |=> $stable(o_run_state))
    else $error("state changed without restart");
endmodule

// file: rtl/pcbl_map.svh
// Constants for the processor control block loader.
// Assumes inclusion by the package and by the loader modules only.
//
// Function
// - The control block is a 176-byte structure fetched by plain physical address, never translated.
// - At start-up the block is read from memory starting at a physical pointer to its first byte.
// - Once cached, only the on-chip copies change; memory is never re-read or written back unprompted.
// - The first segment-table pointer given is taken as a physical address.
// - That pointer yields a segment selector used for every later segment-table access.
// - An interrupt vector number indexes the interrupt table to give the handler pointer.
// - A detected fault produces a fault vector number that indexes the fault table.
// - A fault abandons current work at once and starts the fault handler; unlike an interrupt, it is never deferred by priority;
//   the loader instead drops a fault that arrives while a block load is pending.
// - An interrupt's priority decides whether it is serviced at once or deferred.
// - The multiprocessor preempt flag, when set, enables shared preemption handling.
// - The state field of the controls word selects the state entered at start-up or restart.
// - Cached copies change only through interagent message commands.
// - The state field decodes 00 stopped, 01 reserved, 10 idle, 11 executing.
// - The addressing-mode flag selects physical when 0 and virtual when 1.
// - A restart command re-reads the whole block and reloads every cached field.
`ifndef PCBL_MAP_SVH
`define PCBL_MAP_SVH

// Block geometry
`define PCBL_BLOCK_BYTES     176
`define PCBL_BLOCK_WORDS     44
// Word offsets of the cached fields
`define PCBL_OFS_CTRL        6'd1
`define PCBL_OFS_DISPATCH    6'd3
`define PCBL_OFS_INT_TABLE   6'd4
`define PCBL_OFS_INT_STACK   6'd5
`define PCBL_OFS_REGION3     6'd8
`define PCBL_OFS_SYSPROC     6'd9
`define PCBL_OFS_FAULT_TABLE 6'd10
`define PCBL_OFS_IDLE_LO     6'd12
`define PCBL_OFS_IDLE_HI     6'd13
// Controls word field positions
`define PCBL_BIT_MP_PREEMPT  1
`define PCBL_BIT_STATE_LO    2
`define PCBL_BIT_ADDR_MODE   10
// Reset values
`define PCBL_RST_WORD        32'h0000_0000

`endif

// file: rtl/pcbl_pkg.sv
// Types shared by the control block loader.
// Assumes the constant header sits beside it.
`include "pcbl_map.svh"
package pcbl_pkg;
  typedef enum logic [1:0] {
    PCBL_ST_STOPPED  = 2'b00,
    PCBL_ST_RESERVED = 2'b01,
    PCBL_ST_IDLE     = 2'b10,
    PCBL_ST_EXEC     = 2'b11
  } pcbl_run_t;

  typedef enum logic [1:0] {
    PCBL_MSG_NONE,
    PCBL_MSG_RESTART,
    PCBL_MSG_MODIFY_CTRL
  } pcbl_msg_t;
endpackage

// file: rtl/pcbl_word_reg.sv
// One cached control-block word with a single load port.
// Assumes a single clock and synchronous reset.
`timescale 1ns/100ps
module pcbl_word_reg #(
  parameter int W = 32
) (
  // Clock and reset
  input  wire logic         i_core_clk,
  input  wire logic         i_sys_rst,
  // Load
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_data,
  // Stored value
  output logic      [W-1:0] o_q
);
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  // Next value only on load
  always_comb begin
    q_next = q_reg;
    if (i_load) begin
      q_next = i_data;
    end
  end

  // Register
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign o_q = q_reg;
endmodule

// file: verif/pcbl_loader_test.sv
// Self-checking bench for the control block loader.
// Assumes the memory model answers reads; checks run from queues.
`timescale 1ns/100ps
module pcbl_loader_test;
  import pcbl_pkg::*;
  localparam logic [31:0] SEG = 32'h0000_2000;
  localparam logic [31:0] BLK = 32'h0001_0000;
  logic clk = 1'b0, rst = 1'b1, init = 1'b0, slow = 1'b0;
  logic busy_q = 1'b0, int_req = 1'b0, fault = 1'b0;
  logic [31:0] ctrl_word = 32'h0, msg_data = 32'h0;
  logic [7:0] int_vec = 8'h0, flt_vec = 8'h0;
  logic [4:0] int_prio = 5'h0, cur_prio = 5'h0;
  logic [15:0] rnd = 16'd46388;
  pcbl_msg_t msg = PCBL_MSG_NONE;
  logic mem_req, mem_valid, busy, virt, mp, itake, idefer, ftake;
  logic [31:0] mem_addr, mem_data, seg_sel, disp, istk, reg3, sysp, entry;
  logic [63:0] idle;
  pcbl_run_t run;
  logic [35:0] exp_q[$];
  logic [31:0] addr_q[$];
  int bad_count = 0, n_tests = 0;

  pcbl_loader i_dut (.i_core_clk(clk), .i_sys_rst(rst), .i_init(init),
    .i_block_ptr(BLK), .i_segtab_ptr(SEG), .i_msg_cmd(msg),
    .i_msg_data(msg_data), .o_mem_req(mem_req), .o_mem_addr(mem_addr),
    .i_mem_valid(mem_valid), .i_mem_data(mem_data), .i_int_req(int_req),
    .i_int_vector(int_vec), .i_int_prio(int_prio), .i_cur_prio(cur_prio),
    .i_fault(fault), .i_fault_vector(flt_vec), .o_busy(busy),
    .o_run_state(run), .o_virtual_mode(virt), .o_mp_preempt(mp),
    .o_segtab_sel(seg_sel), .o_dispatch_sel(disp), .o_int_stack(istk),
    .o_region3_sel(reg3), .o_sysproc_sel(sysp), .o_idle_time(idle),
    .o_int_take(itake), .o_int_defer(idefer), .o_fault_take(ftake),
    .o_entry_addr(entry));
  pcbl_mem_model i_mem (.i_core_clk(clk), .i_req(mem_req),
    .i_addr(mem_addr), .o_valid(mem_valid), .o_data(mem_data),
    .i_ctrl_addr(BLK + 32'h4), .i_ctrl_word(ctrl_word), .i_slow(slow));

  initial forever #4 clk = ~clk;

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Expected contents of the memory image, by byte offset in the block
  function automatic logic [31:0] wd(input int ofs);
    logic [31:0] a;
    a = BLK + 32'(ofs);
    return {a[15:0], ~a[15:0]};
  endfunction

  task automatic check(input string nm, input logic [35:0] e, g);
    n_tests++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask
  // Oldest note against what just appeared; an unasked result is a fault
  task automatic take(input logic [3:0] k, input logic [31:0] v);
    if (exp_q.size() == 0) check("unexpected result", 36'h0, {k, v});
    else check("result", exp_q.pop_front(), {k, v});
  endtask

  // Result watcher, sampling away from the driving edge
  always @(negedge clk) begin
    if (mem_req) begin
      if (addr_q.size() == 0) check("stray read", 36'h0, {4'h0, mem_addr});
      else check("read address", {4'h0, addr_q.pop_front()},
                 {4'h0, mem_addr});
    end
    if (busy_q && !busy) begin
      take(4'h0, seg_sel);
      take(4'h0, disp);
      take(4'h0, istk);
      take(4'h0, reg3);
      take(4'h0, sysp);
      take(4'h0, idle[31:0]);
      take(4'h0, idle[63:32]);
      take(4'h0, {28'h0, run, virt, mp});
    end
    if (itake) take(4'h1, entry);
    if (idefer) take(4'h2, 32'h0);
    if (ftake) take(4'h3, entry);
    busy_q = busy;
  end

  // Full load by init or restart; optional stray requests while busy
  task automatic do_load(input logic rs, input logic [1:0] st,
                         input logic v, m, rf);
    int k;
    int offs [6];
    logic [31:0] cw;
    offs = '{12, 20, 32, 36, 48, 52};
    cw = {21'h0, v, 6'h0, st, m, 1'b0};
    ctrl_word <= cw;
    addr_q.push_back(SEG);
    for (k = 0; k < 44; k++) addr_q.push_back(BLK + 32'(4 * k));
    exp_q.push_back({4'h0, 16'(SEG), ~16'(SEG)});
    for (k = 0; k < 6; k++) exp_q.push_back({4'h0, wd(offs[k])});
    exp_q.push_back({4'h0, 28'h0, st, v, m});
    @(posedge clk);
    if (rs) msg <= PCBL_MSG_RESTART;
    else init <= 1'b1;
    @(posedge clk);
    msg <= PCBL_MSG_NONE;
    init <= 1'b0;
    repeat (3) @(posedge clk);
    // Start and fault during the load must both be dropped
    if (rf) begin
      init <= 1'b1;
      fault <= 1'b1;
      @(posedge clk);
      init <= 1'b0;
      fault <= 1'b0;
    end
    for (k = 0; k < 500 && busy; k++) @(posedge clk);
    @(posedge clk);
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #100us;
    bad_count++;
    complete_run();
  end

  initial begin
    int i;
    logic [31:0] tab;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    do_load(1'b0, 2'b10, 1'b0, 1'b0, 1'b1);
    // Every state code, slow and prompt memory, by restart
    for (i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      slow <= rnd[0];
      do_load(1'b1, 2'(i), rnd[1], rnd[2], 1'b0);
    end
    // Modify keeps the state field, changes the other controls
    @(posedge clk);
    msg <= PCBL_MSG_MODIFY_CTRL;
    msg_data <= {21'h0, 1'b1, 6'h0, 2'b00, 1'b1, 1'b0};
    @(posedge clk);
    msg <= PCBL_MSG_NONE;
    repeat (3) @(posedge clk);
    check("modified controls", {33'h0, 2'b11, 1'b1}, {33'h0, run, virt});
    check("modified preempt", 36'h1, {35'h0, mp});
    // Random interrupts and faults, equal priorities included
    for (i = 0; i < 24; i++) begin
      rnd = lfsr(rnd);
      @(posedge clk);
      int_req <= rnd[0] | rnd[1];
      fault <= rnd[2] & rnd[3];
      int_vec <= rnd[15:8];
      flt_vec <= rnd[11:4];
      int_prio <= rnd[8:4];
      cur_prio <= rnd[5] ? rnd[8:4] : rnd[13:9];
      tab = rnd[2] & rnd[3] ? wd(40) + 32'({rnd[11:4], 2'b00})
                             : wd(16) + 32'({rnd[15:8], 2'b00});
      if (rnd[2] & rnd[3]) exp_q.push_back({4'h3, tab});
      else if ((rnd[0] | rnd[1]) && (rnd[5] || rnd[8:4] <= rnd[13:9]))
        exp_q.push_back({4'h2, 32'h0});
      else if (rnd[0] | rnd[1]) exp_q.push_back({4'h1, tab});
      @(posedge clk);
      int_req <= 1'b0;
      fault <= 1'b0;
    end
    repeat (4) @(posedge clk);
    check("pending results", 36'h0, 36'(exp_q.size() + addr_q.size()));
    complete_run();
  end
endmodule

// file: verif/pcbl_mem_model.sv
// Memory model holding the control block and segment table words.
// Assumes one read outstanding and one-cycle request pulses.
`timescale 1ns/100ps
module pcbl_mem_model (
  // Clock
  input  wire logic        i_core_clk,
  // Read port
  input  wire logic        i_req,
  input  wire logic [31:0] i_addr,
  output logic             o_valid,
  output logic [31:0]      o_data,
  // Scenario controls
  input  wire logic [31:0] i_ctrl_addr,
  input  wire logic [31:0] i_ctrl_word,
  input  wire logic        i_slow
);
  logic [1:0]  wait_reg = 2'h0;
  logic [31:0] addr_reg = 32'h0;
  logic        busy_reg = 1'b0;
  initial o_valid = 1'b0;
  initial o_data = 32'h0;
  // Answer after one or three cycles; idle bus toggles so no stale word
  always @(posedge i_core_clk) begin
    o_valid <= 1'b0;
    o_data  <= ~o_data;
    if (i_req) begin
      addr_reg <= i_addr;
      wait_reg <= i_slow ? 2'h2 : 2'h0;
      busy_reg <= 1'b1;
    end else if (busy_reg && wait_reg != 2'h0) begin
      wait_reg <= wait_reg - 2'h1;
    end else if (busy_reg) begin
      busy_reg <= 1'b0;
      o_valid  <= 1'b1;
      // Plain physical image, controls word placed by the bench
      o_data   <= (addr_reg == i_ctrl_addr) ? i_ctrl_word
                : {addr_reg[15:0], ~addr_reg[15:0]};
    end
  end
endmodule
